//--- hdl/swap_skip_table_xor_exec.sv
// Purpose: Executes nibble swaps, zero skips, table reads and exclusive-OR operations
// Assumes: Sequencer holds instr stable while issue is high; program memory answers
//          one cycle after prog_read with prog_word
//          Data memory takes mem_wr in the cycle it is shown
//          Table pointers stay steady while a table read runs
// Notes: The zero flag is the only status bit this unit can change
//        A request is taken on a rising edge with issue high and the unit idle
//        Single-cycle operations answer with done one cycle after being taken
//        A taken skip raises skip_next first and done one cycle later
//        Table reads drive prog_read for one cycle and load prog_addr, which then holds,
//        wait one cycle for the registered memory, then store the word
//        Low table byte goes to data memory, high byte to the latch
//        Issue held past done starts the same operation again
//        Unused operation codes finish in one cycle and change nothing
// Operation
// - Nibble exchange writes back the byte with its nibbles swapped, flags kept.
// - Nibble exchange to work loads swapped byte into work register, memory intact.
// - Skip-if-clear-byte skips the next instruction when the byte is zero.
// - A taken skip adds one dummy cycle, making two instruction cycles.
// - Copy-then-skip copies byte to work register and skips when it is zero.
// - Bit test skips the next instruction when the selected bit is zero.
// - Paged table read uses both pointers; low byte to memory, high to latch.
// - Current-page table read uses code page plus low pointer.
// - Last-page table read uses final page plus low pointer, flags kept.
// - Exclusive-OR from memory updates work register and only the zero flag.
// - Exclusive-OR to memory writes the byte back, updating only the zero flag.
// - Immediate exclusive-OR updates work register and only the zero flag.
`timescale 1ns/1ns
module swap_skip_table_xor_exec (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Request from the sequencer
    input wire logic issue,
    input wire exec_pkg::instr_s instr,
    // Table pointer pair
    input wire logic [exec_pkg::data_width-1:0] table_pointer_low,
    input wire logic [exec_pkg::page_width-1:0] table_pointer_high,
    // Program memory answer
    input wire logic [exec_pkg::prog_width-1:0] prog_word,
    // Handshake back to the sequencer
    output logic busy,
    output logic done,
    output logic skip_next,
    // Results
    output exec_pkg::mem_write_s mem_wr,
    output logic [exec_pkg::data_width-1:0] work_register,
    output logic [exec_pkg::data_width-1:0] table_high_latch,
    output logic zero_flag,
    // Program memory request
    output logic prog_read,
    output logic [exec_pkg::prog_addr_width-1:0] prog_addr
);
    // Sequencer state
    exec_pkg::state_e state;
    exec_pkg::state_e next_state;

    // Operand views
    wire [exec_pkg::data_width-1:0] mem_byte = instr.mem_data;
    wire byte_clear = (mem_byte == exec_pkg::zero_byte);
    wire [exec_pkg::data_width-1:0] swapped;
    wire [exec_pkg::data_width-1:0] bit_hit;
    wire bit_clear = |bit_hit;

    // Nibble exchange and bit selection, one slice per data bit
    for (genvar b = 0; b < exec_pkg::data_width; b++) begin : g_bit
        if (b <= exec_pkg::nibble_lo) begin : g_low
            assign swapped[b] = mem_byte[b + exec_pkg::nibble_hi];
        end else begin : g_high
            assign swapped[b] = mem_byte[b - exec_pkg::nibble_hi];
        end
        assign bit_hit[b] = (int'(instr.bit_sel) == b) & ~mem_byte[b];
    end

    // Exclusive-OR results
    wire [exec_pkg::data_width-1:0] xor_mem = work_register ^ mem_byte;
    wire [exec_pkg::data_width-1:0] xor_imm = work_register ^ instr.immediate;

    // Instruction classes
    wire start = issue && (state == exec_pkg::st_idle);

    // Memory-byte operations
    wire is_swap = (instr.op == exec_pkg::op_nibble_exchange);
    wire is_swap_w = (instr.op == exec_pkg::op_nibble_exchange_to_work);

    // Skip tests
    wire is_sz = (instr.op == exec_pkg::op_skip_if_clear_byte);
    wire is_sza = (instr.op == exec_pkg::op_copy_then_skip_if_clear);
    wire is_szb = (instr.op == exec_pkg::op_skip_if_clear_bit);

    // Table reads
    wire is_tab_p = (instr.op == exec_pkg::op_table_read_paged);
    wire is_tab_c = (instr.op == exec_pkg::op_table_read_current_page);
    wire is_tab_l = (instr.op == exec_pkg::op_table_read_last_page);

    // Exclusive-OR operations
    wire is_xor_w = (instr.op == exec_pkg::op_exclusive_or_to_work);
    wire is_xor_m = (instr.op == exec_pkg::op_exclusive_or_to_memory);
    wire is_xor_i = (instr.op == exec_pkg::op_exclusive_or_immediate);
    wire is_table = is_tab_p | is_tab_c | is_tab_l;

    // Skip decision for the three test instructions
    wire skip_byte = is_sz & byte_clear;
    wire skip_copy = is_sza & byte_clear;
    wire skip_bit = is_szb & bit_clear;
    wire skip_taken = skip_byte | skip_copy | skip_bit;

    // Table address selection by page source
    wire [exec_pkg::page_width-1:0] table_page =
        is_tab_p ? table_pointer_high :
        is_tab_c ? instr.current_page :
        exec_pkg::last_page;
    wire [exec_pkg::prog_addr_width-1:0] next_prog_addr = {table_page, table_pointer_low};

    // Which operations load the work register
    wire load_work = is_swap_w | is_sza | is_xor_w | is_xor_i;
    logic [exec_pkg::data_width-1:0] next_work;
    logic [exec_pkg::data_width-1:0] mem_data_now;

    // Which operations update the zero flag
    wire load_zero = is_xor_w | is_xor_m | is_xor_i;

    // Zero flag source: the exclusive-OR result of this operation
    wire [exec_pkg::data_width-1:0] xor_result = is_xor_i ? xor_imm : xor_mem;
    wire next_zero = (xor_result == exec_pkg::zero_byte);

    // Immediate memory write-back (table reads write later)
    wire mem_write_now = is_swap | is_xor_m;

    // Result selection per operation; others keep the work register
    always_comb begin
        next_work = work_register;
        mem_data_now = mem_byte;
        unique case (instr.op)
            exec_pkg::op_nibble_exchange: begin
                mem_data_now = swapped;
            end
            exec_pkg::op_nibble_exchange_to_work: begin
                next_work = swapped;
            end
            exec_pkg::op_copy_then_skip_if_clear: begin
                next_work = mem_byte;
            end
            exec_pkg::op_exclusive_or_to_work: begin
                next_work = xor_mem;
            end
            exec_pkg::op_exclusive_or_to_memory: begin
                mem_data_now = xor_mem;
            end
            exec_pkg::op_exclusive_or_immediate: begin
                next_work = xor_imm;
            end
            default: begin
                next_work = work_register;
            end
        endcase
    end

    // Sequence slots: memory is read during wait, word is stored from load
    wire table_load_slot = (state == exec_pkg::st_table_load);
    wire dummy_slot = (state == exec_pkg::st_dummy);

    // Taken requests by how long they run
    wire single_cycle = start && !is_table && !skip_taken;
    wire table_start = start && is_table;
    wire skip_start = start && skip_taken;

    // Registered output next values
    wire next_busy = (next_state != exec_pkg::st_idle);
    wire next_done = single_cycle || dummy_slot || table_load_slot;
    wire next_skip = skip_start;
    wire next_prog_read = table_start;

    // Program word halves
    wire [exec_pkg::data_width-1:0] table_low = prog_word[exec_pkg::data_width-1:0];
    wire [exec_pkg::data_width-1:0] table_high = prog_word[exec_pkg::prog_width-1:exec_pkg::data_width];

    // Load enables
    wire load_latch = table_load_slot;
    wire load_prog_addr = table_start;
    wire load_work_now = start && load_work;
    wire load_zero_now = start && load_zero;

    // Write-back: table low byte in the store slot, else the swap or xor result
    wire exec_pkg::mem_write_s next_mem_wr = '{
        write: table_load_slot || (start && mem_write_now),
        data: table_load_slot ? table_low : mem_data_now
    };

    // State sequencing; the wait slot covers the registered memory read
    always_comb begin
        next_state = state;
        unique case (state)
            exec_pkg::st_idle: begin
                if (table_start) begin
                    next_state = exec_pkg::st_table_wait;
                end else if (skip_start) begin
                    next_state = exec_pkg::st_dummy;
                end
            end
            exec_pkg::st_table_wait: begin
                next_state = exec_pkg::st_table_load;
            end
            exec_pkg::st_table_load: begin
                next_state = exec_pkg::st_idle;
            end
            exec_pkg::st_dummy: begin
                next_state = exec_pkg::st_idle;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state <= exec_pkg::st_idle;
        end else begin
            state <= next_state;
        end
    end

    // Busy while a skip or table read is still running
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= next_busy;
        end
    end

    // Done pulse at the end of every operation
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            done <= 1'b0;
        end else begin
            done <= next_done;
        end
    end

    // Skip pulse, one cycle ahead of done
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            skip_next <= 1'b0;
        end else begin
            skip_next <= next_skip;
        end
    end

    // Program memory read pulse
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prog_read <= 1'b0;
        end else begin
            prog_read <= next_prog_read;
        end
    end

    // Program address, held after the read
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prog_addr <= '0;
        end else if (load_prog_addr) begin
            prog_addr <= next_prog_addr;
        end
    end

    // Data memory write-back
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mem_wr <= '0;
        end else begin
            mem_wr <= next_mem_wr;
        end
    end

    // Table high latch
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            table_high_latch <= exec_pkg::latch_reset;
        end else if (load_latch) begin
            table_high_latch <= table_high;
        end
    end

    // Work register; other instructions leave it alone
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            work_register <= exec_pkg::work_reset;
        end else if (load_work_now) begin
            work_register <= next_work;
        end
    end

    // Zero flag; only exclusive-OR operations touch it
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            zero_flag <= 1'b0;
        end else if (load_zero_now) begin
            zero_flag <= next_zero;
        end
    end
endmodule

//--- hdl/exec_pkg.sv
// Purpose: Shared types and constants for the swap/skip/table/xor execution unit
// Assumes: 8-bit data path, program words of prog_width bits
// Notes: Operation codes are local to this unit, not the instruction encoding
package exec_pkg;
    localparam int data_width = 8;
    localparam int prog_width = 16;
    localparam int prog_addr_width = 13;
    localparam int bit_sel_width = 3;
    localparam logic [7:0] zero_byte = 8'h00;
    localparam logic [7:0] work_reset = 8'h00;
    localparam logic [7:0] latch_reset = 8'h00;
    localparam int nibble_lo = 3;
    localparam int nibble_hi = 4;
    // Page bits above the low table pointer
    localparam int page_width = prog_addr_width - data_width;
    localparam logic [page_width-1:0] last_page = {page_width{1'b1}};

    typedef enum logic [3:0] {
        op_none = 4'h0,
        op_nibble_exchange = 4'h1,
        op_nibble_exchange_to_work = 4'h2,
        op_skip_if_clear_byte = 4'h3,
        op_copy_then_skip_if_clear = 4'h4,
        op_skip_if_clear_bit = 4'h5,
        op_table_read_paged = 4'h6,
        op_table_read_current_page = 4'h7,
        op_table_read_last_page = 4'h8,
        op_exclusive_or_to_work = 4'h9,
        op_exclusive_or_to_memory = 4'ha,
        op_exclusive_or_immediate = 4'hb
    } op_e;

    // One decoded instruction presented by the sequencer
    typedef struct packed {
        op_e op;
        logic [data_width-1:0] mem_data;
        logic [data_width-1:0] immediate;
        logic [bit_sel_width-1:0] bit_sel;
        logic [page_width-1:0] current_page;
    } instr_s;

    // Write-back to data memory
    typedef struct packed {
        logic write;
        logic [data_width-1:0] data;
    } mem_write_s;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_table_wait = 2'b01,
        st_dummy = 2'b10,
        st_table_load = 2'b11
    } state_e;
endpackage

//--- testbench/exec_monitor.sv
// Purpose: Port checks for the execution unit
// Assumes: One request in flight, issue dropped once taken
// Notes: Table data is judged by the bench
`timescale 1ns/1ns
module exec_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic issue,
    input wire exec_pkg::instr_s instr,
    input wire logic [7:0] table_pointer_low,
    input wire logic [4:0] table_pointer_high,
    input wire logic [15:0] prog_word,
    input wire logic busy,
    input wire logic done,
    input wire logic skip_next,
    input wire exec_pkg::mem_write_s mem_wr,
    input wire logic [7:0] work_register,
    input wire logic [7:0] table_high_latch,
    input wire logic zero_flag,
    input wire logic prog_read,
    input wire logic [12:0] prog_addr
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Request taken, operands and derived selections
    wire take = issue && !busy && !sys_rst;
    wire exec_pkg::op_e op = instr.op;
    wire [7:0] md = instr.mem_data;
    wire imm = op == exec_pkg::op_exclusive_or_immediate;
    wire [7:0] xsrc = imm ? instr.immediate : md;
    wire [4:0] page = op == exec_pkg::op_table_read_paged ? table_pointer_high :
        op == exec_pkg::op_table_read_current_page ? instr.current_page : exec_pkg::last_page;
    wire tbl = op inside {exec_pkg::op_table_read_paged, exec_pkg::op_table_read_current_page,
        exec_pkg::op_table_read_last_page};
    swap_mem_a: assert property (take && op == exec_pkg::op_nibble_exchange
        |=> mem_wr.write && mem_wr.data == {$past(md[3:0]), $past(md[7:4])} && $stable(zero_flag))
        else $error("nibble exchange write-back wrong");
    swap_work_a: assert property (take && op == exec_pkg::op_nibble_exchange_to_work
        |=> work_register == {$past(md[3:0]), $past(md[7:4])} && !mem_wr.write)
        else $error("nibble exchange to work wrong");
    skip_zero_a: assert property (take && op == exec_pkg::op_skip_if_clear_byte && md == 8'h00
        |=> skip_next && busy ##1 done && !busy) else $error("zero byte skip wrong");
    skip_bit_a: assert property (take && op == exec_pkg::op_skip_if_clear_bit && !md[instr.bit_sel]
        |=> skip_next ##1 done) else $error("clear bit skip wrong");
    no_skip_a: assert property (take && (op == exec_pkg::op_skip_if_clear_byte && md != 8'h00 ||
        op == exec_pkg::op_skip_if_clear_bit && md[instr.bit_sel]) |=> done && !skip_next)
        else $error("skip taken wrongly");
    copy_skip_a: assert property (take && op == exec_pkg::op_copy_then_skip_if_clear
        |=> work_register == $past(md) && skip_next == ($past(md) == 8'h00)) else $error("copy skip wrong");
    table_addr_a: assert property (take && tbl
        |=> prog_read && prog_addr == {$past(page), $past(table_pointer_low)}) else $error("table address wrong");
    xor_acc_a: assert property (take && (imm || op == exec_pkg::op_exclusive_or_to_work)
        |=> work_register == ($past(work_register) ^ $past(xsrc)) && zero_flag == (work_register == 8'h00))
        else $error("xor to work wrong");
    xor_mem_a: assert property (take && op == exec_pkg::op_exclusive_or_to_memory
        |=> mem_wr.data == ($past(work_register) ^ $past(md)) && zero_flag == (mem_wr.data == 8'h00)
        && $stable(work_register)) else $error("xor to memory wrong");
    table_load_a: assert property (take && tbl
        |=> busy ##1 busy ##1 done && !busy && mem_wr.write && mem_wr.data == $past(prog_word[7:0])
        && table_high_latch == $past(prog_word[15:8])) else $error("table word store wrong");
    // Main scenarios reached
    cover property (take && tbl);
    cover property (skip_next);
    cover property (mem_wr.write && zero_flag);
endmodule

//--- testbench/prog_mem_model.sv
// Purpose: Program memory answering table reads
// Assumes: Word is valid the cycle after the read pulse
// Notes: Word inverts every cycle outside a read
`timescale 1ns/1ns
module prog_mem_model (
    input wire logic clock,
    input wire logic prog_read,
    input wire logic [12:0] prog_addr,
    output logic [15:0] prog_word
);
    initial prog_word = 16'h0f0f;
    // Address-derived word, scrambled when not read
    always @(posedge clock) begin
        prog_word <= prog_read ? {prog_addr[7:0] ^ 8'h3c, 3'h2, prog_addr[12:8]} : ~prog_word;
    end
endmodule

//--- testbench/tb_swap_skip_table_xor_exec.sv
// Purpose: Self-checking bench for the execution unit
// Assumes: Inputs driven 1 ns after the rising edge
// Notes: Zero flag set by xor, then held through other ops
`timescale 1ns/1ns
module tb_swap_skip_table_xor_exec;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic issue = 1'b0;
    exec_pkg::instr_s instr = '0;
    logic [7:0] table_pointer_low = 8'h00;
    logic [4:0] table_pointer_high = 5'h00;
    logic [15:0] prog_word;
    logic busy, done, skip_next, zero_flag, prog_read;
    exec_pkg::mem_write_s mem_wr;
    logic [7:0] work_register, table_high_latch;
    logic [12:0] prog_addr;
    int n_fail = 0;
    int samples_checked = 0;
    int c;
    logic s;
    exec_pkg::mem_write_s w;
    swap_skip_table_xor_exec swap_skip_table_xor_exec_inst (.*);
    prog_mem_model prog_mem_model_inst (.*);
    always #5 clock = ~clock;
    task automatic finish_test();
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One op: cycles to done, skip seen, write-back seen
    task automatic run(input exec_pkg::op_e op, input logic [7:0] md, input logic [7:0] im, input logic [2:0] bs);
        @(posedge clock);
        #1;
        instr = '{op, md, im, bs, 5'h0b};
        issue = 1'b1;
        c = 0;
        s = 1'b0;
        w = '0;
        do begin
            @(posedge clock);
            #1;
            issue = 1'b0;
            c++;
            s = s | skip_next;
            if (mem_wr.write === 1'b1) w = mem_wr;
        end while (done !== 1'b1 && c < 20);
        if (c == 20) begin
            n_fail++;
            finish_test();
        end
    endtask
    task automatic test_xor();
        run(exec_pkg::op_exclusive_or_to_work, 8'h5a, 8'h00, 3'h0);
        check({work_register, zero_flag}, {8'h5a, 1'b0});
        run(exec_pkg::op_exclusive_or_to_memory, 8'h5a, 8'h00, 3'h0);
        check({w, work_register, zero_flag}, {9'h100, 8'h5a, 1'b1});
        run(exec_pkg::op_exclusive_or_immediate, 8'h00, 8'h5b, 3'h0);
        check({work_register, zero_flag}, {8'h01, 1'b0});
        run(exec_pkg::op_exclusive_or_immediate, 8'h00, 8'h01, 3'h0);
        check({work_register, zero_flag}, {8'h00, 1'b1});
    endtask
    task automatic test_swap();
        run(exec_pkg::op_nibble_exchange, 8'h3c, 8'h00, 3'h0);
        check({w, zero_flag}, {9'h1c3, 1'b1});
        run(exec_pkg::op_nibble_exchange_to_work, 8'ha5, 8'h00, 3'h0);
        check({w.write, work_register, zero_flag}, {1'b0, 8'h5a, 1'b1});
    endtask
    task automatic test_skip();
        run(exec_pkg::op_skip_if_clear_byte, 8'h00, 8'h00, 3'h0);
        check({c[3:0], s}, {4'h2, 1'b1});
        run(exec_pkg::op_skip_if_clear_byte, 8'h80, 8'h00, 3'h0);
        check({c[3:0], s}, {4'h1, 1'b0});
        run(exec_pkg::op_copy_then_skip_if_clear, 8'h00, 8'h00, 3'h0);
        check({work_register, c[3:0], s}, {8'h00, 4'h2, 1'b1});
        run(exec_pkg::op_copy_then_skip_if_clear, 8'h7e, 8'h00, 3'h0);
        check({work_register, s, zero_flag}, {8'h7e, 1'b0, 1'b1});
        for (int i = 0; i < 8; i++) begin
            run(exec_pkg::op_skip_if_clear_bit, ~(8'h01 << i), 8'h00, i[2:0]);
            check({c[3:0], s}, {4'h2, 1'b1});
            run(exec_pkg::op_skip_if_clear_bit, 8'h01 << i, 8'h00, i[2:0]);
            check({c[3:0], s, zero_flag}, {4'h1, 1'b0, 1'b1});
        end
    endtask
    task automatic test_table();
        table_pointer_low = 8'h96;
        table_pointer_high = 5'h15;
        run(exec_pkg::op_table_read_paged, 8'h00, 8'h00, 3'h0);
        check({w, table_high_latch, c[3:0]}, {9'h155, 8'haa, 4'h3});
        run(exec_pkg::op_table_read_current_page, 8'h00, 8'h00, 3'h0);
        check({w, table_high_latch}, {9'h14b, 8'haa});
        run(exec_pkg::op_table_read_last_page, 8'h00, 8'h00, 3'h0);
        check({w, table_high_latch, zero_flag}, {9'h15f, 8'haa, 1'b1});
    endtask
    initial begin
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        check({busy, done, skip_next, work_register, zero_flag}, 24'h0);
        test_xor();
        test_swap();
        test_skip();
        test_table();
        finish_test();
    end
endmodule
bind swap_skip_table_xor_exec exec_monitor exec_monitor_inst (.*);
